// File: design/sensor_regs_pkg.sv
// register map, field positions and sizes of the result and status group
// assumes byte-wide registers on the device's own serial register port
package sensor_regs_pkg;

	// register offsets
	localparam logic [7:0] ADDR_REF_HIGH    = 8'h16;
	localparam logic [7:0] ADDR_OFFSET_LOW  = 8'h18;
	localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h19;
	localparam logic [7:0] ADDR_INT_SOURCE  = 8'h24;
	localparam logic [7:0] ADDR_BUF_LEVEL   = 8'h25;
	localparam logic [7:0] ADDR_BUF_FLAGS   = 8'h26;
	localparam logic [7:0] ADDR_STATUS      = 8'h27;
	localparam logic [7:0] ADDR_PRESS_LOW   = 8'h28;
	localparam logic [7:0] ADDR_PRESS_MID   = 8'h29;
	localparam logic [7:0] ADDR_PRESS_HIGH  = 8'h2a;
	localparam logic [7:0] ADDR_TEMP_LOW    = 8'h2b;
	localparam logic [7:0] ADDR_TEMP_HIGH   = 8'h2c;
	localparam logic [7:0] ADDR_BUF_PRESS   = 8'h78;

	// interrupt source fields
	localparam int INT_BOOT_BIT   = 7;
	localparam int INT_ACTIVE_BIT = 2;
	localparam int INT_LOW_BIT    = 1;
	localparam int INT_HIGH_BIT   = 0;

	// buffer flag fields
	localparam int BUF_THRESH_BIT = 7;
	localparam int BUF_OVER_BIT   = 6;
	localparam int BUF_FULL_BIT   = 5;

	// sample status fields
	localparam int STAT_T_OVR_BIT = 5;
	localparam int STAT_P_OVR_BIT = 4;
	localparam int STAT_T_AV_BIT  = 1;
	localparam int STAT_P_AV_BIT  = 0;

	// sizes and reset values
	localparam int PRESS_W    = 24;
	localparam int TEMP_W     = 16;
	localparam int OFFSET_W   = 16;
	localparam int THRESH_W   = 7;
	localparam int BUF_DEPTH  = 128;
	localparam logic [15:0] OFFSET_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;

endpackage

// File: design/sample_store.sv
// circular sample store that overwrites its oldest entry when full
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module sample_store #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 128
) (
	// clock and reset
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_b_i,
	// fill side
	input  wire logic                       push_i,
	input  wire logic [WIDTH-1:0]           push_data_i,
	// drain side
	input  wire logic                       pop_i,
	output logic      [WIDTH-1:0]           head_o,
	// fill state
	output logic      [$clog2(DEPTH):0]     level_o,
	output logic                            dropped_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : depth_check
		$error("sample_store depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             do_pop;
	logic             drop;

	assign do_pop    = pop_i && (level_o != '0);
	// a push into a full store with no pop in the same cycle discards the oldest sample
	assign drop      = push_i && !do_pop && (level_o == FULL_LEVEL);
	assign head_o    = mem[rd_ptr];
	assign dropped_o = drop;

	always_ff @(posedge ref_clk_i) begin
		if (push_i) begin
			mem[wr_ptr] <= push_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			level_o <= '0;
		end else begin
			if (push_i) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_pop || drop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push_i && !(do_pop || drop)) begin
				level_o <= level_o + 1'b1;
			end else if (!push_i && do_pop) begin
				level_o <= level_o - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// File: design/pressure_result_status_regs.sv
// result and status registers of the barometric sensor core
// assumes the measurement engine and the serial port logic share ref_clk_i
//
// What this block does
// - holds a signed 16-bit pressure offset, low byte 18h, high byte 19h.
// - interrupt source bit 7 reads 1 during boot, 0 afterwards.
// - interrupt source bit 2 reads 1 when any interrupt event is raised.
// - interrupt source bit 1 set on a low differential pressure event.
// - interrupt source bit 0 set on a high differential pressure event.
// - buffer flags bit 7 is 1 while fill level reaches the threshold.
// - buffer flags bit 6 is 1 when full and a sample was overwritten.
// - buffer flags bit 5 is 1 when completely full, nothing overwritten.
// - status bit 5 set when a temperature result replaces an unread one.
// - status bit 4 set when a pressure result replaces an unread one.
// - status bit 1 is 1 once a new temperature result is produced.
// - status bit 0 is 1 once a new pressure result is produced.
// - the status register is refreshed once per output rate period.
// - pressure result is signed 24-bit, bytes at 2Ah, 29h and 28h.
// - with compensation modes off, pressure equals measurement minus offset.
// - temperature result is signed 16-bit, high byte 2Ch, low byte 2Bh.
// - lowest byte of the oldest buffered pressure sample reads at 78h.
// - the buffer counts as full when it holds 128 unread samples.
`timescale 1ns/1ps
`default_nettype none

module pressure_result_status_regs #(
	parameter int DEPTH = sensor_regs_pkg::BUF_DEPTH
) (
	// clock and reset
	input  wire logic                                  ref_clk_i,
	input  wire logic                                  rst_b_i,
	// register port
	input  wire logic [7:0]                            reg_addr_i,
	input  wire logic                                  reg_wr_i,
	input  wire logic                                  reg_rd_i,
	input  wire logic [7:0]                            reg_wdata_i,
	output logic      [7:0]                            reg_rdata_o,
	output logic                                       reg_rvalid_o,
	// measurement engine
	input  wire logic                                  meas_valid_i,
	input  wire logic [sensor_regs_pkg::PRESS_W-1:0]   meas_press_i,
	input  wire logic [sensor_regs_pkg::TEMP_W-1:0]    meas_temp_i,
	input  wire logic                                  rate_tick_i,
	// compensation mode selects
	input  wire logic                                  differential_select_i,
	input  wire logic                                  automatic_zeroing_i,
	input  wire logic                     automatic_reference_capture_i,
	// reference, events and configuration from the rest of the core
	input  wire logic [sensor_regs_pkg::OFFSET_W-1:0]  ref_pressure_i,
	input  wire logic                                  boot_busy_i,
	input  wire logic                                  low_event_i,
	input  wire logic                                  high_event_i,
	input  wire logic [sensor_regs_pkg::THRESH_W-1:0]  threshold_i
);
	localparam int LVL_W = $clog2(DEPTH) + 1;
	localparam logic [LVL_W-1:0] FULL_LEVEL = LVL_W'(DEPTH);

	if (DEPTH > 255 || DEPTH < 2) begin : depth_check
		$error("buffer depth must fit the 8-bit level register");
	end

	// register port decode
	logic rd_int;
	logic rd_stat;
	logic rd_press_high;
	logic rd_temp_high;
	logic rd_buf;
	logic wr_off_low;
	logic wr_off_high;

	assign rd_int = reg_rd_i && reg_addr_i == sensor_regs_pkg::ADDR_INT_SOURCE;
	assign rd_stat = reg_rd_i && reg_addr_i == sensor_regs_pkg::ADDR_STATUS;
	assign rd_press_high = reg_rd_i &&
		reg_addr_i == sensor_regs_pkg::ADDR_PRESS_HIGH;
	assign rd_temp_high = reg_rd_i &&
		reg_addr_i == sensor_regs_pkg::ADDR_TEMP_HIGH;
	assign rd_buf = reg_rd_i && reg_addr_i == sensor_regs_pkg::ADDR_BUF_PRESS;
	assign wr_off_low = reg_wr_i &&
		reg_addr_i == sensor_regs_pkg::ADDR_OFFSET_LOW;
	assign wr_off_high = reg_wr_i &&
		reg_addr_i == sensor_regs_pkg::ADDR_OFFSET_HIGH;

	// calibration offset
	logic [sensor_regs_pkg::OFFSET_W-1:0] pressure_offset_value;
	logic [sensor_regs_pkg::PRESS_W-1:0]  offset_ext;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pressure_offset_value <= sensor_regs_pkg::OFFSET_RESET;
		end else begin
			if (wr_off_low) begin
				pressure_offset_value[7:0] <= reg_wdata_i;
			end
			if (wr_off_high) begin
				pressure_offset_value[15:8] <= reg_wdata_i;
			end
		end
	end

	// sign extension keeps negative offsets correct in the 24-bit sum
	assign offset_ext = {{8{pressure_offset_value[15]}},
		pressure_offset_value};

	// result formation
	logic [sensor_regs_pkg::PRESS_W-1:0] next_press;
	logic                                comp_active;

	assign comp_active = differential_select_i || automatic_zeroing_i ||
		automatic_reference_capture_i;

	always_comb begin
		// other modes deliver an already referenced value from the engine
		if (comp_active) begin
			next_press = meas_press_i;
		end else begin
			next_press = meas_press_i - offset_ext;
		end
	end

	// a finished measurement waits here until the next rate tick
	logic [sensor_regs_pkg::PRESS_W-1:0] pend_press;
	logic [sensor_regs_pkg::TEMP_W-1:0]  pend_temp;
	logic                                pend_valid;
	logic                                commit;

	assign commit = rate_tick_i && pend_valid;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pend_press <= '0;
			pend_temp  <= '0;
		end else if (meas_valid_i) begin
			pend_press <= next_press;
			pend_temp  <= meas_temp_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pend_valid <= 1'b0;
		end else begin
			pend_valid <= meas_valid_i || (pend_valid && !rate_tick_i);
		end
	end

	// published results
	logic [sensor_regs_pkg::PRESS_W-1:0] pressure_result;
	logic [sensor_regs_pkg::TEMP_W-1:0]  temperature_result;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pressure_result    <= '0;
			temperature_result <= '0;
		end else if (commit) begin
			pressure_result    <= pend_press;
			temperature_result <= pend_temp;
		end
	end

	// sample status; a new sample beats a clearing read in the same cycle
	logic pressure_available_flag;
	logic temperature_available_flag;
	logic press_overrun_flag;
	logic temp_overrun_flag;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pressure_available_flag    <= 1'b0;
			temperature_available_flag <= 1'b0;
		end else begin
			pressure_available_flag <= commit ||
				(pressure_available_flag && !rd_press_high);
			temperature_available_flag <= commit ||
				(temperature_available_flag && !rd_temp_high);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			press_overrun_flag <= 1'b0;
			temp_overrun_flag  <= 1'b0;
		end else begin
			press_overrun_flag <= (commit && pressure_available_flag &&
				!rd_press_high) || (press_overrun_flag && !rd_stat);
			temp_overrun_flag <= (commit && temperature_available_flag &&
				!rd_temp_high) || (temp_overrun_flag && !rd_stat);
		end
	end

	// threshold events, sticky until the interrupt source is read
	logic low_event_flag;
	logic high_event_flag;
	logic interrupt_active_flag;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			low_event_flag  <= 1'b0;
			high_event_flag <= 1'b0;
		end else begin
			low_event_flag  <= low_event_i ||
				(low_event_flag && !rd_int);
			high_event_flag <= high_event_i ||
				(high_event_flag && !rd_int);
		end
	end

	assign interrupt_active_flag = low_event_flag || high_event_flag;

	// sample buffer
	logic [sensor_regs_pkg::PRESS_W-1:0] buf_head;
	logic [LVL_W-1:0]                    buf_level;
	logic                                buf_dropped;
	logic                                buffer_overwrite_flag;
	logic                                buffer_threshold_flag;
	logic                                buffer_complete_flag;

	sample_store #(
		.WIDTH (sensor_regs_pkg::PRESS_W),
		.DEPTH (DEPTH)
	) u_store (
		.ref_clk_i   (ref_clk_i),
		.rst_b_i     (rst_b_i),
		.push_i      (commit),
		.push_data_i (pend_press),
		.pop_i       (rd_buf),
		.head_o      (buf_head),
		.level_o     (buf_level),
		.dropped_o   (buf_dropped)
	);

	// overwrite stays flagged until a read makes room again
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			buffer_overwrite_flag <= 1'b0;
		end else begin
			buffer_overwrite_flag <= buf_dropped ||
				(buffer_overwrite_flag && !rd_buf);
		end
	end

	assign buffer_threshold_flag = buf_level >= LVL_W'(threshold_i);
	assign buffer_complete_flag  = (buf_level == FULL_LEVEL) &&
		!buffer_overwrite_flag;

	// read data
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = sensor_regs_pkg::BYTE_ZERO;
		case (reg_addr_i)
			sensor_regs_pkg::ADDR_REF_HIGH: begin
				next_rdata = ref_pressure_i[15:8];
			end
			sensor_regs_pkg::ADDR_OFFSET_LOW: begin
				next_rdata = pressure_offset_value[7:0];
			end
			sensor_regs_pkg::ADDR_OFFSET_HIGH: begin
				next_rdata = pressure_offset_value[15:8];
			end
			sensor_regs_pkg::ADDR_INT_SOURCE: begin
				next_rdata[sensor_regs_pkg::INT_BOOT_BIT] = boot_busy_i;
				next_rdata[sensor_regs_pkg::INT_ACTIVE_BIT] =
					interrupt_active_flag;
				next_rdata[sensor_regs_pkg::INT_LOW_BIT] = low_event_flag;
				next_rdata[sensor_regs_pkg::INT_HIGH_BIT] = high_event_flag;
			end
			sensor_regs_pkg::ADDR_BUF_LEVEL: begin
				next_rdata = 8'(buf_level);
			end
			sensor_regs_pkg::ADDR_BUF_FLAGS: begin
				next_rdata[sensor_regs_pkg::BUF_THRESH_BIT] =
					buffer_threshold_flag;
				next_rdata[sensor_regs_pkg::BUF_OVER_BIT] =
					buffer_overwrite_flag;
				next_rdata[sensor_regs_pkg::BUF_FULL_BIT] =
					buffer_complete_flag;
			end
			sensor_regs_pkg::ADDR_STATUS: begin
				next_rdata[sensor_regs_pkg::STAT_T_OVR_BIT] = temp_overrun_flag;
				next_rdata[sensor_regs_pkg::STAT_P_OVR_BIT] = press_overrun_flag;
				next_rdata[sensor_regs_pkg::STAT_T_AV_BIT] =
					temperature_available_flag;
				next_rdata[sensor_regs_pkg::STAT_P_AV_BIT] =
					pressure_available_flag;
			end
			sensor_regs_pkg::ADDR_PRESS_LOW: begin
				next_rdata = pressure_result[7:0];
			end
			sensor_regs_pkg::ADDR_PRESS_MID: begin
				next_rdata = pressure_result[15:8];
			end
			sensor_regs_pkg::ADDR_PRESS_HIGH: begin
				next_rdata = pressure_result[23:16];
			end
			sensor_regs_pkg::ADDR_TEMP_LOW: begin
				next_rdata = temperature_result[7:0];
			end
			sensor_regs_pkg::ADDR_TEMP_HIGH: begin
				next_rdata = temperature_result[15:8];
			end
			sensor_regs_pkg::ADDR_BUF_PRESS: begin
				// an empty buffer returns zero rather than a stale entry
				if (buf_level != '0) begin
					next_rdata = buf_head[7:0];
				end
			end
			default: begin
				next_rdata = sensor_regs_pkg::BYTE_ZERO;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o  <= sensor_regs_pkg::BYTE_ZERO;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata;
			end
		end
	end

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	offset_write_a: assert property (wr_off_low |=>
		pressure_offset_value[7:0] == $past(reg_wdata_i))
		else $error("offset low byte not stored");

	boot_flag_a: assert property (rd_int |=> reg_rvalid_o &&
		reg_rdata_o[7] == $past(boot_busy_i))
		else $error("boot bit does not follow boot phase");

	event_active_a: assert property (low_event_flag && rd_int |=>
		reg_rdata_o[2] && reg_rdata_o[1])
		else $error("low event not reported as active");

	threshold_read_a: assert property (rd_buf == 1'b0 &&
		reg_rd_i && reg_addr_i == sensor_regs_pkg::ADDR_BUF_FLAGS |=>
		reg_rdata_o[7] == ($past(buf_level) >= $past(LVL_W'(threshold_i))))
		else $error("threshold flag wrong");

	full_flag_a: assert property (commit && !rd_buf &&
		buf_level == FULL_LEVEL - 1'b1 |=> buffer_complete_flag)
		else $error("full buffer not flagged");

	overwrite_a: assert property (buf_dropped |=>
		buffer_overwrite_flag && !buffer_complete_flag)
		else $error("overwrite not flagged");

	press_math_a: assert property (meas_valid_i && !comp_active |=>
		pend_press == $past(meas_press_i) - $past(offset_ext))
		else $error("pressure not offset corrected");

	press_avail_a: assert property (commit ##1 (!rd_press_high)[*2] |->
		pressure_available_flag)
		else $error("pressure available lost");

	avail_clear_a: assert property (rd_press_high && !commit |=>
		!pressure_available_flag)
		else $error("pressure available not cleared");

	press_overrun_a: assert property (commit && pressure_available_flag &&
		!rd_press_high && !rd_stat |=> press_overrun_flag)
		else $error("pressure overrun missed");

	tick_update_a: assert property (!rate_tick_i |=>
		$stable(pressure_result))
		else $error("result changed off the rate tick");

	overrun_seen_c: cover property (commit ##1 press_overrun_flag);
	buffer_drop_c: cover property (buf_dropped);
	result_read_c: cover property (commit ##[1:20] rd_press_high);

endmodule

`default_nettype wire

// File: bench/reg_host.sv
// host model on the byte strobe register port of the result registers
// assumes commands arrive off the rising edge of ref_clk_i
`timescale 1ns/1ps
`default_nettype none

module reg_host (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_b_i,
	// command side
	input  wire logic       go_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	output logic            done_o,
	// register port
	output logic      [7:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i
);
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			reg_rd_o <= 1'b0;
			reg_wr_o <= 1'b0;
			reg_addr_o <= 8'h00;
			reg_wdata_o <= 8'h00;
		end else if (go_i) begin
			reg_rd_o <= !wr_i;
			reg_wr_o <= wr_i;
			reg_addr_o <= addr_i;
			reg_wdata_o <= wdata_i;
		end else begin
			reg_rd_o <= 1'b0;
			reg_wr_o <= 1'b0;
			// idle bus inverts address and write data every cycle, so every second idle cycle shows the last request again
			reg_addr_o <= ~reg_addr_o;
			reg_wdata_o <= ~reg_wdata_o;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			done_o <= 1'b0;
			rdata_o <= 8'h00;
		end else begin
			done_o <= reg_wr_o | reg_rvalid_i;
			if (reg_rvalid_i) begin
				rdata_o <= reg_rdata_i;
			end
		end
	end
endmodule

`default_nettype wire

// File: bench/pressure_result_status_regs_tb.sv
// self-checking bench for the result and status registers
// assumes the reg_host model drives the register port
`timescale 1ns/1ps
`default_nettype none

module pressure_result_status_regs_tb;
	// shortened buffer so fill and drain stay brief
	localparam int DEPTH = 8;
	logic        ref_clk_i, rst_b_i, go, wr, done, rwr, rrd, rvalid;
	logic        mvalid, tick, dsel, zsel, rsel, boot, lev, hev;
	logic [7:0]  addr, wdata, rdata, raddr, rwdata, rrdata, d;
	logic [23:0] press, p, pr;
	logic [15:0] temp, t, tr, refp, off;
	logic [6:0]  thresh;
	logic [7:0]  lows [0:8];
	int          errors, cmp_count, n, seed_val;

	pressure_result_status_regs #(.DEPTH(DEPTH)) dut (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(raddr),
		.reg_wr_i(rwr), .reg_rd_i(rrd), .reg_wdata_i(rwdata),
		.reg_rdata_o(rrdata), .reg_rvalid_o(rvalid),
		.meas_valid_i(mvalid), .meas_press_i(press), .meas_temp_i(temp),
		.rate_tick_i(tick), .differential_select_i(dsel),
		.automatic_zeroing_i(zsel), .automatic_reference_capture_i(rsel),
		.ref_pressure_i(refp), .boot_busy_i(boot), .low_event_i(lev),
		.high_event_i(hev), .threshold_i(thresh));

	reg_host host (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .go_i(go), .wr_i(wr),
		.addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .done_o(done),
		.reg_addr_o(raddr), .reg_wr_o(rwr), .reg_rd_o(rrd),
		.reg_wdata_o(rwdata), .reg_rdata_i(rrdata), .reg_rvalid_i(rvalid));

	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic access(input logic w, input logic [7:0] a,
			input logic [7:0] v);
		@(negedge ref_clk_i);
		go = 1'b1;
		wr = w;
		addr = a;
		wdata = v;
		@(negedge ref_clk_i);
		go = 1'b0;
		for (n = 0; n < 20 && done !== 1'b1; n++) @(negedge ref_clk_i);
		if (n == 20) begin
			errors++;
			finish_test();
		end else begin
			d = rdata;
		end
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		access(1'b0, a, 8'h00);
		check({16'h0000, d}, {16'h0000, exp});
	endtask

	task automatic commit(input logic [23:0] pv, input logic [15:0] tv);
		@(negedge ref_clk_i);
		press = pv;
		temp = tv;
		mvalid = 1'b1;
		@(negedge ref_clk_i);
		mvalid = 1'b0;
		tick = 1'b1;
		@(negedge ref_clk_i);
		tick = 1'b0;
		press = ~pv;
		temp = ~tv;
		@(negedge ref_clk_i);
	endtask

	task automatic do_reset();
		@(negedge ref_clk_i);
		rst_b_i = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
	endtask

	function automatic logic [23:0] exp_press(input logic [23:0] pv,
			input logic [15:0] o, input logic pass);
		return pass ? pv : pv - {{8{o[15]}}, o};
	endfunction

	function automatic logic [7:0] exp_flags(input int pushes);
		int lvl;
		lvl = (pushes > DEPTH) ? DEPTH : pushes;
		return {lvl >= int'(thresh), pushes > DEPTH, pushes == DEPTH,
			5'b0_0000};
	endfunction

	initial begin
		errors = 0;
		cmp_count = 0;
		{go, wr, mvalid, tick, dsel, zsel, rsel, boot, lev, hev} = '0;
		addr = 8'h00;
		wdata = 8'h00;
		press = 24'h00_0000;
		temp = 16'h0000;
		thresh = 7'h04;
		refp = 16'h0000;
		rst_b_i = 1'b0;
		seed_val = $urandom(32'hdd9f_2a6b);
		repeat (8) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		chk_rd(sensor_regs_pkg::ADDR_INT_SOURCE, 8'h00);
		chk_rd(sensor_regs_pkg::ADDR_BUF_LEVEL, 8'h00);
		chk_rd(sensor_regs_pkg::ADDR_BUF_FLAGS, 8'h00);
		chk_rd(sensor_regs_pkg::ADDR_OFFSET_LOW, 8'h00);
		access(1'b1, sensor_regs_pkg::ADDR_STATUS, 8'hff);
		chk_rd(sensor_regs_pkg::ADDR_STATUS, 8'h00);
		boot = 1'b1;
		chk_rd(sensor_regs_pkg::ADDR_INT_SOURCE, 8'h80);
		boot = 1'b0;
		refp = 16'($urandom);
		chk_rd(sensor_regs_pkg::ADDR_REF_HIGH, refp[15:8]);
		chk_rd(8'h30, 8'h00);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin
			off = (k == 0) ? 16'h8000 : 16'($urandom);
			p = (k == 0) ? 24'h00_0000 : 24'($urandom);
			t = 16'($urandom);
			dsel = (k % 4 == 1);
			zsel = (k % 4 == 2);
			rsel = (k % 4 == 3);
			access(1'b1, sensor_regs_pkg::ADDR_OFFSET_LOW, off[7:0]);
			access(1'b1, sensor_regs_pkg::ADDR_OFFSET_HIGH, off[15:8]);
			chk_rd(sensor_regs_pkg::ADDR_OFFSET_HIGH, off[15:8]);
			commit(p, t);
			chk_rd(sensor_regs_pkg::ADDR_STATUS, 8'h03);
			access(1'b0, sensor_regs_pkg::ADDR_PRESS_LOW, 8'h00);
			pr[7:0] = d;
			access(1'b0, sensor_regs_pkg::ADDR_PRESS_MID, 8'h00);
			pr[15:8] = d;
			access(1'b0, sensor_regs_pkg::ADDR_PRESS_HIGH, 8'h00);
			pr[23:16] = d;
			check(pr, exp_press(p, off, k % 4 != 0));
			access(1'b0, sensor_regs_pkg::ADDR_TEMP_LOW, 8'h00);
			tr[7:0] = d;
			access(1'b0, sensor_regs_pkg::ADDR_TEMP_HIGH, 8'h00);
			tr[15:8] = d;
			check({8'h00, tr}, {8'h00, t});
			chk_rd(sensor_regs_pkg::ADDR_STATUS, 8'h00);
		end
		$display("test results done");
		commit(24'($urandom), 16'($urandom));
		commit(24'($urandom), 16'($urandom));
		chk_rd(sensor_regs_pkg::ADDR_STATUS, 8'h33);
		chk_rd(sensor_regs_pkg::ADDR_STATUS, 8'h03);
		access(1'b0, sensor_regs_pkg::ADDR_PRESS_HIGH, 8'h00);
		access(1'b0, sensor_regs_pkg::ADDR_TEMP_HIGH, 8'h00);
		@(negedge ref_clk_i);
		tick = 1'b1;
		@(negedge ref_clk_i);
		tick = 1'b0;
		chk_rd(sensor_regs_pkg::ADDR_STATUS, 8'h00);
		$display("test overrun done");
		for (int e = 1; e < 4; e++) begin
			@(negedge ref_clk_i);
			lev = e[1];
			hev = e[0];
			@(negedge ref_clk_i);
			{lev, hev} = 2'b00;
			chk_rd(sensor_regs_pkg::ADDR_INT_SOURCE,
				{6'b00_0001, e[1:0]});
			chk_rd(sensor_regs_pkg::ADDR_INT_SOURCE, 8'h00);
		end
		$display("test events done");
		do_reset();
		// threshold drawn anew so the level compare sees more than one value
		thresh = 7'(1 + $urandom % DEPTH);
		for (int i = 0; i <= DEPTH; i++) begin
			p = 24'($urandom);
			lows[i] = p[7:0];
			commit(p, 16'($urandom));
			n = (i + 1 > DEPTH) ? DEPTH : i + 1;
			chk_rd(sensor_regs_pkg::ADDR_BUF_LEVEL, 8'(n));
			chk_rd(sensor_regs_pkg::ADDR_BUF_FLAGS, exp_flags(i + 1));
		end
		for (int j = 1; j <= DEPTH; j++) begin
			chk_rd(sensor_regs_pkg::ADDR_BUF_PRESS, lows[j]);
			chk_rd(sensor_regs_pkg::ADDR_BUF_LEVEL, 8'(DEPTH - j));
			chk_rd(sensor_regs_pkg::ADDR_BUF_FLAGS, exp_flags(DEPTH - j));
		end
		chk_rd(sensor_regs_pkg::ADDR_BUF_PRESS, 8'h00);
		chk_rd(sensor_regs_pkg::ADDR_BUF_LEVEL, 8'h00);
		$display("test buffer done");
		finish_test();
	end
endmodule

`default_nettype wire
